// ==== verilog/fpet_pkg.sv ====
package fpet_pkg;

  // ----------------------------------------------------------------
  // Clock and timing generator range
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 200000;   // System clock, 5 ns period
  localparam int unsigned TMR_FREQ_MIN_KHZ = 257;  // Lowest timing generator rate
  localparam int unsigned TMR_FREQ_MAX_KHZ = 476;  // Highest timing generator rate

  // Divider limits: highest rate rounds the ratio up, lowest rounds it down
  localparam logic [9:0] DIV_MIN =
    10'((CLK_FREQ_KHZ + TMR_FREQ_MAX_KHZ - 1) / TMR_FREQ_MAX_KHZ);
  localparam logic [9:0] DIV_MAX = 10'(CLK_FREQ_KHZ / TMR_FREQ_MIN_KHZ);
  localparam logic [9:0] DIV_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Step durations in timing generator periods
  // ----------------------------------------------------------------
  localparam logic [13:0] WORD_PERIODS = 14'h001e;       // 30
  localparam logic [13:0] BLK_FIRST_PERIODS = 14'h0019;  // 25
  localparam logic [13:0] BLK_NEXT_PERIODS = 14'h0012;   // 18
  localparam logic [13:0] BLK_END_PERIODS = 14'h0006;    // 6
  localparam logic [13:0] MASS_PERIODS = 14'h2961;       // 10593
  localparam logic [13:0] SEG_PERIODS = 14'h12d3;        // 4819
  localparam logic [5:0] BLK_LAST_POS = 6'h3f;           // Position 63
  localparam logic [13:0] CNT_RESET = 14'h0000;
  localparam logic [5:0] POS_RESET = 6'h00;

  // Cumulative limits that the requesting side keeps
  localparam int unsigned MASS_CUM_MIN_MS = 20;
  localparam int unsigned PROG_CUM_MAX_MS = 10;

  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPET_CMD_WORD = 2'b00,
    FPET_CMD_BLOCK = 2'b01,
    FPET_CMD_MASS = 2'b10,
    FPET_CMD_SEG = 2'b11
  } fpet_cmd_e;

  typedef enum logic [2:0] {
    FPET_IDLE = 3'b000,
    FPET_WORD = 3'b001,
    FPET_BLK_FIRST = 3'b010,
    FPET_BLK_NEXT = 3'b011,
    FPET_BLK_WAIT = 3'b100,
    FPET_BLK_END = 3'b101,
    FPET_MASS = 3'b110,
    FPET_SEG = 3'b111
  } fpet_state_e;

endpackage

// ==== verilog/fpet_tick_div.sv ====
`timescale 1ns/1ps

// Timing generator: one-cycle tick every div clocks, ratio kept in range
module fpet_tick_div (
  input wire logic clk_i,          // System clock
  input wire logic reset_i,        // Synchronous reset
  input wire logic [9:0] div_i,    // Requested division ratio
  output logic tick_o              // One-cycle timing generator tick
);
  import fpet_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } fpet_div_s;

  fpet_div_s r;
  fpet_div_s next_r;
  logic [9:0] ratio;

  // ----------------------------------------------------------------
  // Ratio clamp and count
  // ----------------------------------------------------------------
  // Out-of-range settings are pulled into the legal rate band
  always_comb begin
    if (div_i < DIV_MIN) begin
      ratio = DIV_MIN;
    end else if (div_i > DIV_MAX) begin
      ratio = DIV_MAX;
    end else begin
      ratio = div_i;
    end
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt >= ratio - 10'h001) begin
      next_r.cnt = DIV_RESET;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 10'h001;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '{cnt: DIV_RESET, tick: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign tick_o = r.tick;

  // No tick follows another within eight cycles
  tick_space_a: assert property (@(posedge clk_i) disable iff (reset_i)
    tick_o |=> !tick_o [*8])
    else $error("Timing ticks too close together");

endmodule

// ==== verilog/fpet_seq.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------------
// ------------------------------------------------------------------
module fpet_seq (
  input wire logic clk_i,                 // 200 MHz system clock
  input wire logic reset_i,               // Synchronous reset, active high
  input wire logic [9:0] div_i,           // Timing generator division ratio
  input wire logic start_i,               // Request strobe, taken when idle
  input wire fpet_pkg::fpet_cmd_e cmd_i,  // Operation with the request
  input wire logic blk_next_i,            // Next block word is present
  input wire logic blk_end_i,             // Terminate the block program
  output logic busy_o,                    // Operation in progress
  output logic done_o,                    // Operation finished, one cycle
  output logic word_ack_o,                // Block word written, one cycle
  output logic blk_wait_o                 // Block waits for next word or end
);
  import fpet_pkg::*;

  typedef struct packed {
    fpet_state_e state;
    logic [13:0] cnt;
    logic [5:0] pos;
    logic busy;
    logic done;
    logic ack;
    logic wait_flag;
  } fpet_s;

  fpet_s r;
  fpet_s next_r;
  logic tick;
  logic last;

  // ----------------------------------------------------------------
  // Timing generator
  // ----------------------------------------------------------------
  // Period source for all timed steps
  fpet_tick_div u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .div_i(div_i),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Final period of the running step
  assign last = tick && (r.cnt == CNT_RESET);

  // Next-state logic for all operations
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.ack = 1'b0;
    case (r.state)
      FPET_IDLE: begin
        if (start_i) begin
          next_r.busy = 1'b1;
          next_r.pos = POS_RESET;
          case (cmd_i)
            FPET_CMD_WORD: begin
              next_r.state = FPET_WORD;
              next_r.cnt = WORD_PERIODS - 14'h0001;
            end
            FPET_CMD_BLOCK: begin
              next_r.state = FPET_BLK_FIRST;
              next_r.cnt = BLK_FIRST_PERIODS - 14'h0001;
            end
            FPET_CMD_MASS: begin
              next_r.state = FPET_MASS;
              next_r.cnt = MASS_PERIODS - 14'h0001;
            end
            default: begin
              next_r.state = FPET_SEG;
              next_r.cnt = SEG_PERIODS - 14'h0001;
            end
          endcase
        end
      end
      FPET_WORD, FPET_MASS, FPET_SEG, FPET_BLK_END: begin
        if (last) begin
          next_r.state = FPET_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end else if (tick) begin
          next_r.cnt = r.cnt - 14'h0001;
        end
      end
      FPET_BLK_FIRST, FPET_BLK_NEXT: begin
        if (last) begin
          next_r.ack = 1'b1;
          if (r.pos == BLK_LAST_POS) begin
            next_r.state = FPET_BLK_END;
            next_r.cnt = BLK_END_PERIODS - 14'h0001;
          end else begin
            next_r.state = FPET_BLK_WAIT;
            next_r.wait_flag = 1'b1;
          end
        end else if (tick) begin
          next_r.cnt = r.cnt - 14'h0001;
        end
      end
      FPET_BLK_WAIT: begin
        // Termination wins over a further word in the same cycle
        if (blk_end_i) begin
          next_r.state = FPET_BLK_END;
          next_r.cnt = BLK_END_PERIODS - 14'h0001;
          next_r.wait_flag = 1'b0;
        end else if (blk_next_i) begin
          next_r.state = FPET_BLK_NEXT;
          next_r.cnt = BLK_NEXT_PERIODS - 14'h0001;
          next_r.pos = r.pos + 6'h01;
          next_r.wait_flag = 1'b0;
        end
      end
      default: begin
        next_r.state = FPET_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '{state: FPET_IDLE, cnt: CNT_RESET, pos: POS_RESET, busy: 1'b0,
             done: 1'b0, ack: 1'b0, wait_flag: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs come straight from the state register
  assign busy_o = r.busy;
  assign done_o = r.done;
  assign word_ack_o = r.ack;
  assign blk_wait_o = r.wait_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Ticks seen since the current step began
  logic [13:0] h_ticks;
  always_ff @(posedge clk_i) begin
    if (reset_i || (next_r.state != r.state) || (r.state == FPET_BLK_WAIT)) begin
      h_ticks <= CNT_RESET;
    end else if (tick) begin
      h_ticks <= h_ticks + 14'h0001;
    end
  end

  sequence step_end_s(fpet_state_e st);
    (r.state == st) && last;
  endsequence

  sequence back_idle_s;
    done_o && !busy_o && (r.state == FPET_IDLE);
  endsequence

  word_time_a: assert property (step_end_s(FPET_WORD) |->
    h_ticks == WORD_PERIODS - 14'h0001)
    else $error("Word program length wrong");
  blk_first_time_a: assert property (step_end_s(FPET_BLK_FIRST) |->
    h_ticks == BLK_FIRST_PERIODS - 14'h0001)
    else $error("First block word length wrong");
  blk_next_time_a: assert property (step_end_s(FPET_BLK_NEXT) |->
    h_ticks == BLK_NEXT_PERIODS - 14'h0001 && r.pos != POS_RESET)
    else $error("Further block word length wrong");
  blk_end_time_a: assert property (step_end_s(FPET_BLK_END) |->
    h_ticks == BLK_END_PERIODS - 14'h0001 ##1 back_idle_s)
    else $error("Block end sequence wrong");
  seg_time_a: assert property (step_end_s(FPET_SEG) |->
    h_ticks == SEG_PERIODS - 14'h0001 ##1 back_idle_s)
    else $error("Segment erase length wrong");
  mass_time_a: assert property (step_end_s(FPET_MASS) |->
    h_ticks == MASS_PERIODS - 14'h0001 ##1 back_idle_s)
    else $error("Mass erase length wrong");
  busy_start_a: assert property ((r.state == FPET_IDLE && start_i) |=>
    busy_o throughout (!done_o [*8]))
    else $error("Busy not held after acceptance");
  busy_steady_a: assert property (!done_o && !$past(done_o) &&
    (r.state != FPET_IDLE) |-> busy_o)
    else $error("Busy dropped during operation");

  // ----------------------------------------------------------------
  // Step counter, word acknowledge and block wait checks, reachable within short runs
  // ----------------------------------------------------------------
  // A request of the given kind taken while idle
  sequence accept_s(fpet_cmd_e c);
    (r.state == FPET_IDLE) && start_i && (cmd_i == c);
  endsequence

  // A period boundary inside a running timed step that is not its last
  sequence mid_tick_s;
    tick && !last && (r.state != FPET_IDLE) && (r.state != FPET_BLK_WAIT);
  endsequence

  // Erases are far too long to finish in a test, so their loaded lengths are checked here
  mass_load_a: assert property (accept_s(FPET_CMD_MASS) |=>
    (r.state == FPET_MASS) && (r.cnt == MASS_PERIODS - 14'h0001))
    else $error("Mass erase length not loaded");
  seg_load_a: assert property (accept_s(FPET_CMD_SEG) |=>
    (r.state == FPET_SEG) && (r.cnt == SEG_PERIODS - 14'h0001))
    else $error("Segment erase length not loaded");
  count_step_a: assert property (mid_tick_s |=>
    r.cnt == $past(r.cnt) - 14'h0001)
    else $error("Step counter missed a period");
  count_hold_a: assert property (busy_o && !tick && (r.state != FPET_BLK_WAIT) |=>
    $stable(r.cnt))
    else $error("Step counter moved between periods");
  ack_pulse_a: assert property (word_ack_o |=> !word_ack_o)
    else $error("Word acknowledge longer than one cycle");
  wait_busy_a: assert property (blk_wait_o |->
    busy_o && (r.state == FPET_BLK_WAIT))
    else $error("Block wait shown outside a busy block");

endmodule

// ==== dv/fpet_host.sv ====
`timescale 1ns/1ps

// Host model: issues program and erase requests toward the sequencer
module fpet_host (
  input wire logic clk_i,             // System clock
  output logic [9:0] div_o,           // Timing generator ratio
  output logic start_o,               // Request strobe
  output fpet_pkg::fpet_cmd_e cmd_o,  // Operation code
  output logic next_o,                // Next block word present
  output logic end_o                  // Terminate the block
);
  import fpet_pkg::*;
  // Idle levels from time zero
  initial begin
    div_o = DIV_MIN;
    start_o = 1'b0;
    cmd_o = FPET_CMD_WORD;
    next_o = 1'b0;
    end_o = 1'b0;
  end
  // Ratio always chosen inside the legal generator range
  task automatic set_div(input int r);
    div_o = 10'(r);
  endtask
  // One-cycle strobe, raised after an edge and dropped after the next one
  task automatic pulse(input logic s, input logic n, input logic e, input fpet_cmd_e c);
    start_o = s;
    cmd_o = c;
    next_o = n;
    end_o = e;
    @(posedge clk_i);
    #1;
    start_o = 1'b0;
    next_o = 1'b0;
    end_o = 1'b0;
  endtask
endmodule

// ==== dv/flash_program_erase_timer_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("Error %s expected %0h seen %0h", nm, e, g); end end

module flash_program_erase_timer_tb;
  import fpet_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] div_i;
  logic start_i;
  fpet_cmd_e cmd_i;
  logic blk_next_i;
  logic blk_end_i;
  logic busy_o;
  logic done_o;
  logic word_ack_o;
  logic blk_wait_o;
  int failures = 0;
  int checks = 0;
  int r;
  int q[$];
  fpet_cmd_e ec[2] = '{FPET_CMD_SEG, FPET_CMD_MASS};

  always #2.5 clk_i = ~clk_i;

  fpet_seq u_dut (.clk_i(clk_i), .reset_i(reset_i), .div_i(div_i), .start_i(start_i),
    .cmd_i(cmd_i), .blk_next_i(blk_next_i), .blk_end_i(blk_end_i), .busy_o(busy_o),
    .done_o(done_o), .word_ack_o(word_ack_o), .blk_wait_o(blk_wait_o));

  fpet_host u_host (.clk_i(clk_i), .div_o(div_i), .start_o(start_i), .cmd_o(cmd_i),
    .next_o(blk_next_i), .end_o(blk_end_i));

  // Prints the counts and the verdict, then stops
  task automatic end_sim();
    $display("Checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Waits for done or a word ack, checks it falls in period n; pokes ignored strobes
  task automatic wait_ev(input logic ack, input int n, input logic wt, input int poke);
    int t;
    logic hit;
    t = 0;
    hit = 1'b0;
    while (!hit && t <= n * r + 1) begin
      @(posedge clk_i);
      #1;
      t++;
      if (poke > 0 && t == poke) begin
        u_host.start_o = 1'b1;
        u_host.next_o = 1'b1;
      end else if (poke > 0 && t == poke + 1) begin
        u_host.start_o = 1'b0;
        u_host.next_o = 1'b0;
      end
      hit = ack ? (word_ack_o === 1'b1) : (done_o === 1'b1);
      if (t == 1) `CHK("wait drop", 1'b0, blk_wait_o)
      if (!hit || ack) `CHK("busy", 1'b1, busy_o)
      `CHK("other pulse", 1'b0, ack ? done_o : word_ack_o)
    end
    `CHK("step time", 1'b1, hit && t >= (n - 1) * r + 1 && t <= n * r)
    `CHK("wait level", wt, blk_wait_o)
    if (!ack) `CHK("busy end", 1'b0, busy_o)
  endtask

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    end_sim();
  end

  // Main sequence
  initial begin
    r = $urandom(32'hc32f9799);
    repeat (16) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    // Erases start and hold, then a reset lands mid-step
    foreach (ec[i]) begin
      u_host.pulse(1'b1, 1'b0, 1'b0, ec[i]);
      repeat (1000) begin
        @(posedge clk_i);
        #1;
        `CHK("erase hold", 2'b10, {busy_o, done_o})
      end
      reset_i = 1'b1;
      @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      `CHK("reset idle", 2'b00, {busy_o, done_o})
    end
    // Word program, refused poke inside, then back to back
    r = int'(DIV_MIN) + $urandom % 40;
    u_host.set_div(r);
    u_host.pulse(1'b1, 1'b0, 1'b0, FPET_CMD_WORD);
    wait_ev(1'b0, 30, 1'b0, 7);
    u_host.pulse(1'b1, 1'b0, 1'b0, FPET_CMD_WORD);
    wait_ev(1'b0, 30, 1'b0, 0);
    // Short block, kept far below the cumulative limit; end beats next
    r = int'(DIV_MIN) + $urandom % 40;
    u_host.set_div(r);
    q = '{25, 18, 18};
    u_host.pulse(1'b1, 1'b0, 1'b0, FPET_CMD_BLOCK);
    foreach (q[i]) begin
      wait_ev(1'b1, q[i], 1'b1, 3);
      repeat (1 + $urandom % 4) begin
        @(posedge clk_i);
        #1;
        `CHK("wait hold", 2'b10, {blk_wait_o, word_ack_o})
      end
      u_host.pulse(1'b0, 1'b1, i == 2, FPET_CMD_BLOCK);
    end
    wait_ev(1'b0, 6, 1'b0, 0);
    @(posedge clk_i);
    #1;
    `CHK("done pulse", 2'b00, {busy_o, done_o})
    end_sim();
  end
endmodule
